// file: pll_pkg.sv
// Constants for the synthesiser divider chain, plus the reloading down-counter.
// Assumes every input is synchronous to clock_i; slow inputs are edge-detected.
package pll_pkg;
    localparam int          REF_W        = 11;
    localparam int          MAIN_W       = 10;
    localparam int          SWAL_W       = 7;
    localparam int          SER_BITS     = REF_W + MAIN_W + SWAL_W;
    localparam int          NBITS_W      = 5;
    localparam logic [4:0]  SER_FULL     = 5'h1c;
    // Field positions in the shift register after a full and a short load
    localparam int          FULL_REF_LO  = 0;
    localparam int          FULL_MAIN_LO = REF_W;
    localparam int          FULL_SWAL_LO = REF_W + MAIN_W;
    localparam int          SHORT_MAIN_LO = 0;
    localparam int          SHORT_SWAL_LO = MAIN_W;
    // Latch values before the first load
    localparam logic [REF_W-1:0]  REF_RST  = 11'h003;
    localparam logic [MAIN_W-1:0] MAIN_RST = 10'h008;
    localparam logic [SWAL_W-1:0] SWAL_RST = 7'h00;
    // Fine comparator window, longest time, rounded down to clock cycles
    localparam int          CLK_PERIOD_PS = 4000;
    localparam int          FINE_WIN_PS   = 20000;
    localparam int          ERR_W         = 16;
    localparam logic [ERR_W-1:0] FINE_WIN_CYC =
        ERR_W'((FINE_WIN_PS / CLK_PERIOD_PS) < 1 ? 1 : (FINE_WIN_PS / CLK_PERIOD_PS));
    localparam logic [ERR_W-1:0] ERR_MAX  = 16'hffff;
endpackage

`timescale 1ns/10ps
module ratio_counter #(
    parameter int W = 10
) (
    input  wire logic         clock_i,   // System clock
    input  wire logic         resetn_i,  // Synchronous reset, active low
    input  wire logic         clk_en_i,  // Freezes state when low
    input  wire logic         tick_i,    // One count event
    input  wire logic [W-1:0] ratio_i,   // Latched division ratio
    output logic              term_o     // Pulse on the tick that leaves zero
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } cnt_state_t;

    cnt_state_t st_r;
    cnt_state_t st_nxt;

    assign term_o = tick_i && (st_r.cnt == '0);

    always_comb begin
        st_nxt = st_r;
        if (tick_i) begin
            // new ratio adopted only at zero
            if (st_r.cnt == '0) begin
                st_nxt.cnt = W'(ratio_i - 1'b1);
            end else begin
                st_nxt.cnt = W'(st_r.cnt - 1'b1);
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            st_r <= '0;
        end else if (clk_en_i) begin
            st_r <= st_nxt;
        end
    end
endmodule

// file: pll_divider_chain.sv
// Divider chain, coarse phase detector, ramp timing and serial loader.
// Assumes osc, prescaler and serial pins are synchronous and slower than clock_i.
`timescale 1ns/10ps
module pll_divider_chain (
    input  wire logic clock_i,               // System clock, 250 MHz
    input  wire logic resetn_i,              // Synchronous reset, active low
    input  wire logic clk_en_i,              // Freezes all state when low
    input  wire logic osc_i,                 // Oscillator level
    input  wire logic prescaler_i,           // Prescaler output level
    input  wire logic ser_clk_i,             // Serial clock
    input  wire logic ser_data_i,            // Serial data
    input  wire logic ser_enable_i,          // Serial enable, load on fall
    output logic      modulus_control_n_o,   // Prescaler modulus select
    output logic      coarse_phase_out_o,    // Coarse pin level, high = up
    output logic      coarse_phase_oe_o,     // Coarse pin driven
    output logic      lock_detect_n_o,       // Open drain level, always low
    output logic      lock_detect_n_oe_o,    // Pulls low when locked
    output logic      ramp_run_o,            // Fine ramp running
    output logic      sample_a_o,            // First ramp sample strobe
    output logic      sample_b_o,            // Second ramp sample strobe
    output logic      ref_pulse_o,           // Comparison-rate reference event
    output logic      main_pulse_o           // Comparison-rate main event
);
    import pll_pkg::*;

    typedef struct packed {
        logic                sclk_q;
        logic                en_q;
        logic                osc_q;
        logic                pre_q;
        logic [SER_BITS-1:0] shift;
        logic [NBITS_W-1:0]  nbits;
        logic [REF_W-1:0]    ref_lat;
        logic [MAIN_W-1:0]   main_lat;
        logic [SWAL_W-1:0]   swal_lat;
        logic [SWAL_W-1:0]   swal_cnt;
        logic                half;
        logic                up;
        logic                dn;
        logic [ERR_W-1:0]    err;
        logic                in_win;
        logic                ramp;
        logic                samp_a;
        logic                samp_b;
        logic                ref_p;
        logic                main_p;
    } chain_state_t;

    chain_state_t st_r;
    chain_state_t st_nxt;

    logic osc_tick;
    logic pre_tick;
    logic ref_term;
    logic main_term;
    logic ref_ev;
    logic sclk_fall;
    logic en_fall;
    logic en_rise;

    // Rising edge of a slow level against its previous sample
    function automatic logic rise_of(input logic now_v, input logic was_v);
        rise_of = now_v && !was_v;
    endfunction

    // Falling edge of a slow level against its previous sample
    function automatic logic fall_of(input logic now_v, input logic was_v);
        fall_of = was_v && !now_v;
    endfunction

    // Error pulse short enough to count as inside the fine window
    function automatic logic inside_win(input logic [ERR_W-1:0] width);
        inside_win = (width <= FINE_WIN_CYC);
    endfunction

    // Swallow count used up, modulus back to the short divide
    function automatic logic swal_done(input logic [SWAL_W-1:0] cnt);
        swal_done = (cnt == '0);
    endfunction

    // All three words clocked in, so the reference latch may be replaced
    function automatic logic word_full(input logic [NBITS_W-1:0] n);
        word_full = (n == SER_FULL);
    endfunction

    assign osc_tick  = rise_of(osc_i, st_r.osc_q);
    assign pre_tick  = rise_of(prescaler_i, st_r.pre_q);
    assign sclk_fall = ser_enable_i && st_r.en_q && fall_of(ser_clk_i, st_r.sclk_q);
    assign en_fall   = fall_of(ser_enable_i, st_r.en_q);
    assign en_rise   = rise_of(ser_enable_i, st_r.en_q);
    // fixed divide by two after reference divider
    assign ref_ev    = ref_term && st_r.half;

    ratio_counter #(.W(REF_W)) u_ref_div (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .clk_en_i (clk_en_i),
        .tick_i   (osc_tick),
        .ratio_i  (st_r.ref_lat),
        .term_o   (ref_term)
    );

    ratio_counter #(.W(MAIN_W)) u_main_div (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .clk_en_i (clk_en_i),
        .tick_i   (pre_tick),
        .ratio_i  (st_r.main_lat),
        .term_o   (main_term)
    );

    always_comb begin
        st_nxt        = st_r;
        st_nxt.sclk_q = ser_clk_i;
        st_nxt.en_q   = ser_enable_i;
        st_nxt.osc_q  = osc_i;
        st_nxt.pre_q  = prescaler_i;
        st_nxt.ref_p  = ref_ev;
        st_nxt.main_p = main_term;

        if (ref_term) begin
            st_nxt.half = !st_r.half;
        end

        // swallow counter, reloaded when the main count wraps
        if (main_term) begin
            // swallow adopts its latch only at cycle restart
            st_nxt.swal_cnt = st_r.swal_lat;
        end else if (pre_tick && !swal_done(st_r.swal_cnt)) begin
            st_nxt.swal_cnt = SWAL_W'(st_r.swal_cnt - 1'b1);
        end

        // shift MSB first, count edges up to a full word
        if (en_rise) begin
            st_nxt.nbits = '0;
        end else if (sclk_fall) begin
            st_nxt.shift = {st_r.shift[SER_BITS-2:0], ser_data_i};
            if (!word_full(st_r.nbits)) begin
                st_nxt.nbits = NBITS_W'(st_r.nbits + 1'b1);
            end
        end

        // enable fall transfers the shift register
        if (en_fall) begin
            if (word_full(st_r.nbits)) begin
                st_nxt.ref_lat  = st_r.shift[FULL_REF_LO +: REF_W];
                st_nxt.main_lat = st_r.shift[FULL_MAIN_LO +: MAIN_W];
                st_nxt.swal_lat = st_r.shift[FULL_SWAL_LO +: SWAL_W];
            end else begin
                // short load keeps the reference latch
                st_nxt.main_lat = st_r.shift[SHORT_MAIN_LO +: MAIN_W];
                st_nxt.swal_lat = st_r.shift[SHORT_SWAL_LO +: SWAL_W];
            end
        end

        // Coarse phase/frequency detector
        st_nxt.up = st_r.up || ref_ev;
        st_nxt.dn = st_r.dn || main_term;
        if (st_r.up || st_r.dn) begin
            if (st_r.err != ERR_MAX) begin
                st_nxt.err = ERR_W'(st_r.err + 1'b1);
            end
        end
        if (st_nxt.up && st_nxt.dn) begin
            st_nxt.up  = 1'b0;
            st_nxt.dn  = 1'b0;
            st_nxt.err = '0;
            // window decided by error pulse width
            st_nxt.in_win = inside_win(st_r.err);
        end else if (!inside_win(st_r.err)) begin
            st_nxt.in_win = 1'b0;
        end

        // ramp started by first event, stopped by second
        st_nxt.samp_a = 1'b0;
        st_nxt.samp_b = st_r.samp_a;
        if (ref_ev || main_term) begin
            if (st_r.ramp || (ref_ev && main_term)) begin
                st_nxt.ramp   = 1'b0;
                st_nxt.samp_a = 1'b1;
            end else begin
                st_nxt.ramp = 1'b1;
            end
        end

        // resynchronise detector inputs on load
        // Lock flag is kept; the first wide pulse after a reload clears it
        if (en_fall) begin
            st_nxt.up   = 1'b0;
            st_nxt.dn   = 1'b0;
            st_nxt.err  = '0;
            st_nxt.ramp = 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            st_r          <= '0;
            st_r.en_q     <= 1'b0;
            st_r.ref_lat  <= REF_RST;
            st_r.main_lat <= MAIN_RST;
            st_r.swal_lat <= SWAL_RST;
        end else if (clk_en_i) begin
            st_r <= st_nxt;
        end
    end

    // low while swallow runs, high until main count ends
    assign modulus_control_n_o = swal_done(st_r.swal_cnt);
    assign coarse_phase_out_o  = st_r.up;
    assign coarse_phase_oe_o   = !st_r.in_win;
    // lock pulled low as coarse output releases
    assign lock_detect_n_o     = 1'b0;
    assign lock_detect_n_oe_o  = st_r.in_win;
    assign ramp_run_o          = st_r.ramp;
    assign sample_a_o          = st_r.samp_a;
    assign sample_b_o          = st_r.samp_b;
    assign ref_pulse_o         = st_r.ref_p;
    assign main_pulse_o        = st_r.main_p;
endmodule

// file: pll_divider_chain_props.sv
// Concurrent checks on the divider chain outputs.
// Assumes clock_i is the only clock and the checker is bound to pll_divider_chain.
`timescale 1ns/10ps
module pll_divider_chain_props (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic osc_i,
    input wire logic prescaler_i,
    input wire logic ser_clk_i,
    input wire logic ser_data_i,
    input wire logic ser_enable_i,
    input wire logic modulus_control_n_o,
    input wire logic coarse_phase_out_o,
    input wire logic coarse_phase_oe_o,
    input wire logic lock_detect_n_o,
    input wire logic lock_detect_n_oe_o,
    input wire logic ramp_run_o,
    input wire logic sample_a_o,
    input wire logic sample_b_o,
    input wire logic ref_pulse_o,
    input wire logic main_pulse_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i || !clk_en_i);
    sequence s_dbl;
        sample_a_o ##1 sample_b_o;
    endsequence
    a_reset_state: assert property ($rose(resetn_i) |-> modulus_control_n_o
        && coarse_phase_oe_o && !lock_detect_n_oe_o && !ramp_run_o) else $error("bad reset");
    a_lock_level: assert property (lock_detect_n_o == 1'b0) else $error("lock level");
    a_lock_coarse: assert property (lock_detect_n_oe_o |-> !coarse_phase_oe_o)
        else $error("coarse driven while locked");
    a_samp_pair: assert property (sample_a_o |-> s_dbl) else $error("no second sample");
    a_samp_cause: assert property (sample_b_o |-> $past(sample_a_o)) else $error("lone b");
    a_ref_gap: assert property (ref_pulse_o |=> !ref_pulse_o [*8]) else $error("ref gap");
    a_main_gap: assert property (main_pulse_o |=> !main_pulse_o [*8])
        else $error("main gap");
    a_freeze_hold: assert property (disable iff (!resetn_i) !clk_en_i |=>
        $stable({modulus_control_n_o, coarse_phase_oe_o, ramp_run_o, lock_detect_n_oe_o}))
        else $error("state moved while frozen");
    a_coarse_clear: assert property (main_pulse_o |-> !coarse_phase_out_o)
        else $error("up level left set after main event");
    a_ramp_stop: assert property (sample_a_o |-> !ramp_run_o) else $error("ramp still on");
endmodule
bind pll_divider_chain pll_divider_chain_props u_props (.*);

// file: prescaler_model.sv
// Dual-modulus prescaler fed by one virtual input cycle per clock.
// Assumes the chain counts rising edges of the output.
`timescale 1ns/10ps
module prescaler_model #(
    parameter int P = 4
) (
    input  wire logic clock_i,             // Virtual input rate
    input  wire logic modulus_control_n_i, // Low selects P+1
    output logic      prescaler_o          // One-cycle pulse per period
);
    int cnt = 0;
    int len = P;
    initial prescaler_o = 1'b0;
    always @(posedge clock_i) begin
        cnt <= (cnt >= len - 1) ? 0 : cnt + 1;
        if (cnt >= len - 1) begin
            len <= modulus_control_n_i ? P : P + 1;
        end
        prescaler_o <= (cnt >= len - 1);
    end
endmodule

// file: pll_divider_chain_tb.sv
// Self-checking bench: serial host, oscillator and prescaler model.
// Assumes a 2-cycle oscillator period and a divide-by-4/5 prescaler.
`timescale 1ns/10ps
module pll_divider_chain_tb;
    localparam int P = 4;
    logic clock_i = 1'b0, resetn_i = 1'b0, clk_en_i = 1'b1, osc_i = 1'b0;
    logic ser_clk_i = 1'b0, ser_data_i = 1'b0, ser_enable_i = 1'b0;
    logic prescaler_i, mc_n, coarse_oe, lock_oe, ref_p, main_p;
    int   error_cnt = 0;
    int   cmp_count = 0;
    always #2 clock_i = ~clock_i;
    always @(posedge clock_i) osc_i <= #1 ~osc_i;
    prescaler_model #(.P(P)) u_pre (.clock_i(clock_i), .modulus_control_n_i(mc_n),
        .prescaler_o(prescaler_i));
    pll_divider_chain u_dut (.clock_i(clock_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
        .osc_i(osc_i), .prescaler_i(prescaler_i), .ser_clk_i(ser_clk_i),
        .ser_data_i(ser_data_i), .ser_enable_i(ser_enable_i), .modulus_control_n_o(mc_n),
        .coarse_phase_out_o(), .coarse_phase_oe_o(coarse_oe), .lock_detect_n_o(),
        .lock_detect_n_oe_o(lock_oe), .ramp_run_o(), .sample_a_o(), .sample_b_o(),
        .ref_pulse_o(ref_p), .main_pulse_o(main_p));
    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic stop_test;
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // Cycles between pulses, skipping intervals that may straddle a reload
    task automatic meas(input bit m, input int exp);
        int n;
        repeat (3) begin
            n = 0;
            do begin
                step(1);
                n++;
                if (n > 20000) begin
                    error_cnt++;
                    stop_test();
                end
            end while ((m ? main_p : ref_p) !== 1'b1);
        end
        chk(n, exp);
    endtask
    task automatic ser_load(input logic [27:0] w, input int nb);
        ser_enable_i = 1'b1;
        step(2);
        for (int i = nb - 1; i >= 0; i--) begin
            ser_data_i = w[i];
            ser_clk_i = 1'b1;
            step(1);
            ser_clk_i = 1'b0;
            step(1);
        end
        ser_enable_i = 1'b0;
        ser_data_i = ~ser_data_i;
        step(1);
    endtask
    // Bounded wait for the lock pin to reach a level
    task automatic wait_lock(input logic lvl);
        int k;
        k = 0;
        while (lock_oe !== lvl) begin
            step(1);
            k++;
            if (k > 5000) begin
                error_cnt++;
                stop_test();
            end
        end
    endtask
    // Periods 32 and 33 drift, so lock is both lost and found again
    task automatic t_lock;
        ser_load({7'd1, 10'd8, 11'd8}, 28);
        wait_lock(1'b0);
        chk(32'(coarse_oe), 32'h1);
        wait_lock(1'b1);
        chk(32'(lock_oe), 32'h1);
        chk(32'(coarse_oe), 32'h0);
    endtask
    task automatic t_short;
        ser_load({7'd7, 10'd8, 11'd2047}, 28);
        meas(1'b1, 8 * P + 7);
        ser_load({11'h0, 7'd127, 10'd1023}, 17);
        meas(1'b0, 4 * 2047);
        meas(1'b1, 1023 * P + 127);
    endtask
    // Ignored ones would land in the shift register read by an empty load
    task automatic t_ignore;
        ser_load({11'h0, 7'd0, 10'd8}, 17);
        for (int i = 0; i < 28; i++) begin
            ser_data_i = 1'b1;
            ser_clk_i = 1'b1;
            step(1);
            ser_clk_i = 1'b0;
            step(1);
        end
        clk_en_i = 1'b0;
        step(4);
        clk_en_i = 1'b1;
        ser_load(28'h0, 0);
        meas(1'b0, 4 * 2047);
        meas(1'b1, 8 * P);
    endtask
    initial begin
        step(6);
        chk(32'({mc_n, coarse_oe, lock_oe}), 32'h6);
        resetn_i = 1'b1;
        meas(1'b0, 4 * 3);
        meas(1'b1, 8 * P);
        t_lock();
        t_short();
        t_ignore();
        stop_test();
    end
endmodule
